//--- rtl/regulator_ch3_pkg.sv
// constants for the channel 3 configuration registers
package regulator_ch3_pkg;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] TARGET_OFFSET     = 8'h0e;
  localparam logic [7:0] ENABLE_OFFSET     = 8'h0f;
  localparam logic [7:0] RAMP_OFFSET       = 8'h10;
  localparam logic [7:0] TARGET_RESET      = 8'h00;
  localparam logic [7:0] ENABLE_RESET      = 8'h00;
  localparam logic [7:0] RAMP_RESET        = 8'h00;
  localparam logic [7:0] ENABLE_WRITE_MASK = 8'h0f;
  localparam logic [7:0] RAMP_WRITE_MASK   = 8'h3f;

  // ****************************************
  // field positions
  // ****************************************
  localparam int DISCHARGE_BIT    = 3;
  localparam int ENSEL_MSB        = 2;
  localparam int ENSEL_LSB        = 0;
  localparam int ENSEL_FORCED_BIT = 2;
  localparam int ENSEL_ON_BIT     = 1;
  localparam int SLEW_SELECT_BIT  = 5;
  localparam int LATENCY_BIT      = 4;
  localparam int RISE_SLEW_LSB    = 0;
  localparam int CHANNEL_COUNT    = 4;
  localparam int CH3_INDEX        = 3;

  // ****************************************
  // voltage decode, units of 0.1 mV
  // ****************************************
  localparam logic [15:0] BASE_TENTH_MV   = 16'h1388;
  localparam logic [15:0] COARSE_STEP     = 16'h00fa;
  localparam logic [15:0] FINE_STEP       = 16'h007d;
  localparam logic [7:0]  MAX_COARSE_CODE = 8'hc8;

  // ****************************************
  // slew rates in mV/us
  // ****************************************
  localparam logic [3:0] SLOW_RISE_RATE = 4'h2;
  localparam logic [3:0] NORMAL_RATE    = 4'h5;
  localparam logic [3:0] FAST_RATE      = 4'ha;

  // ****************************************
  // ramp latency timing
  // ****************************************
  localparam int REF_CLK_MHZ          = 50;
  localparam int LONG_LATENCY_US      = 100;
  localparam int SHORT_LATENCY_US     = 10;
  localparam int LONG_LATENCY_CYCLES  = LONG_LATENCY_US * REF_CLK_MHZ;
  localparam int SHORT_LATENCY_CYCLES = SHORT_LATENCY_US * REF_CLK_MHZ;
  localparam int LATENCY_COUNT_WIDTH  = 16;

  typedef enum logic [0:0] {
    RAMP_IDLE,
    RAMP_WAIT
  } ramp_state_t;

endpackage

//--- rtl/ch3_output_control.sv
// channel 3 voltage, enable and discharge decode
`timescale 1ns/1ps
`default_nettype none

module ch3_output_control (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // configuration fields
  input  wire logic [7:0]  ch3_target_code_in,
  input  wire logic        ch3_fine_step_select_in,
  input  wire logic        ch3_discharge_enable_in,
  input  wire logic [2:0]  ch3_enable_select_in,
  input  wire logic [3:0]  power_sequencer_slot_in,
  // decoded outputs
  output logic [15:0]      ch3_voltage_out,
  output logic             ch3_code_reserved_out,
  output logic             ch3_enabled_out,
  output logic             ch3_discharge_resistor_on_out
);

  logic [15:0] step_d;
  logic [15:0] voltage_d;
  logic        enabled_d;

  // ****************************************
  // decode
  // ****************************************
  always_comb begin
    step_d = ch3_fine_step_select_in ? regulator_ch3_pkg::FINE_STEP : regulator_ch3_pkg::COARSE_STEP;
    voltage_d = 16'(regulator_ch3_pkg::BASE_TENTH_MV + 16'(step_d * {8'h00, ch3_target_code_in}));
    if (ch3_enable_select_in[regulator_ch3_pkg::ENSEL_FORCED_BIT]) begin
      enabled_d = ch3_enable_select_in[regulator_ch3_pkg::ENSEL_ON_BIT];
    end else begin
      enabled_d = power_sequencer_slot_in[ch3_enable_select_in[1:0]];
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ch3_voltage_out               <= regulator_ch3_pkg::BASE_TENTH_MV;
      ch3_code_reserved_out         <= 1'b0;
      ch3_enabled_out               <= 1'b0;
      ch3_discharge_resistor_on_out <= 1'b0;
    end else begin
      ch3_voltage_out               <= voltage_d;
      ch3_code_reserved_out         <= !ch3_fine_step_select_in
                                       && (ch3_target_code_in > regulator_ch3_pkg::MAX_COARSE_CODE);
      ch3_enabled_out               <= enabled_d;
      ch3_discharge_resistor_on_out <= ch3_discharge_enable_in && !enabled_d;
    end
  end

endmodule
`default_nettype wire

//--- rtl/regulator_ch3_config_regs.sv
// channel 3 configuration and ramp slew control registers
//
// Function
// - with fine step clear the target code means 0.5 V plus 25 mV per step, up to 5.5 V at 0xc8.
// - with fine step set the target code means 0.5 V plus 12.5 mV per step, up to 3.6875 V.
// - with discharge enable clear a disabled channel 3 output is left undriven.
// - with discharge enable set a disabled channel 3 switches its discharge resistor to power ground.
// - enable select codes 0 to 3 tie channel 3 to power sequencer slots 0 to 3.
// - enable select codes 4 and 5 force channel 3 off, codes 6 and 7 force it on.
// - slew select bit 5 picks a fast ramp of 5 mV/us when clear and 10 mV/us when set.
// - latency mode bit 4 cuts ramp start delay from about 100 us to about 10 us, ignored when rise slew is clear.
// - each rise slew bit gives 2 mV/us when clear and the slew select rate when set.
`timescale 1ns/1ps
`default_nettype none

module regulator_ch3_config_regs #(
  parameter int LONG_LATENCY_CYCLES = regulator_ch3_pkg::LONG_LATENCY_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // register port
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  // external controls
  input  wire logic        ch3_fine_step_select_in,
  input  wire logic [3:0]  power_sequencer_slot_in,
  // channel 3 state
  output logic [15:0]      ch3_voltage_out,
  output logic             ch3_code_reserved_out,
  output logic             ch3_enabled_out,
  output logic             ch3_discharge_resistor_on_out,
  output logic             ch3_ramp_start_out,
  // ramp settings for all channels
  output logic [15:0]      rise_slew_rate_out,
  output logic [3:0]       short_latency_out
);

  localparam int CW = regulator_ch3_pkg::LATENCY_COUNT_WIDTH;

  logic [7:0]                     target_q;
  logic [7:0]                     enable_q;
  logic [7:0]                     ramp_q;
  logic [CW-1:0]                  wait_count_q;
  regulator_ch3_pkg::ramp_state_t ramp_state_q;
  logic                           target_write;
  logic [CW-1:0]                  latency_load;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction

  function automatic logic [3:0] rise_rate(input logic rise_bit, input logic fast_bit);
    if (!rise_bit) begin
      rise_rate = regulator_ch3_pkg::SLOW_RISE_RATE;
    end else if (fast_bit) begin
      rise_rate = regulator_ch3_pkg::FAST_RATE;
    end else begin
      rise_rate = regulator_ch3_pkg::NORMAL_RATE;
    end
  endfunction

  // ****************************************
  // register writes
  // ****************************************
  assign target_write = reg_write_in && reg_hit(reg_addr_in, regulator_ch3_pkg::TARGET_OFFSET);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      target_q <= regulator_ch3_pkg::TARGET_RESET;
    end else if (target_write) begin
      target_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      enable_q <= regulator_ch3_pkg::ENABLE_RESET;
    end else if (reg_write_in && reg_hit(reg_addr_in, regulator_ch3_pkg::ENABLE_OFFSET)) begin
      enable_q <= reg_wdata_in & regulator_ch3_pkg::ENABLE_WRITE_MASK;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ramp_q <= regulator_ch3_pkg::RAMP_RESET;
    end else if (reg_write_in && reg_hit(reg_addr_in, regulator_ch3_pkg::RAMP_OFFSET)) begin
      ramp_q <= reg_wdata_in & regulator_ch3_pkg::RAMP_WRITE_MASK;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      if (reg_hit(reg_addr_in, regulator_ch3_pkg::TARGET_OFFSET)) begin
        reg_rdata_out <= target_q;
      end else if (reg_hit(reg_addr_in, regulator_ch3_pkg::ENABLE_OFFSET)) begin
        reg_rdata_out <= enable_q;
      end else if (reg_hit(reg_addr_in, regulator_ch3_pkg::RAMP_OFFSET)) begin
        reg_rdata_out <= ramp_q;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // ****************************************
  // per channel ramp settings
  // ****************************************
  for (genvar ch = 0; ch < regulator_ch3_pkg::CHANNEL_COUNT; ch++) begin : g_channel
    always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
        rise_slew_rate_out[ch*4 +: 4] <= regulator_ch3_pkg::SLOW_RISE_RATE;
        short_latency_out[ch]         <= 1'b0;
      end else begin
        rise_slew_rate_out[ch*4 +: 4] <= rise_rate(ramp_q[regulator_ch3_pkg::RISE_SLEW_LSB + ch],
                                                   ramp_q[regulator_ch3_pkg::SLEW_SELECT_BIT]);
        short_latency_out[ch]         <= ramp_q[regulator_ch3_pkg::LATENCY_BIT]
                                         && ramp_q[regulator_ch3_pkg::RISE_SLEW_LSB + ch];
      end
    end
  end

  // ****************************************
  // channel 3 ramp start delay
  // ****************************************
  assign latency_load = (ramp_q[regulator_ch3_pkg::LATENCY_BIT]
                         && ramp_q[regulator_ch3_pkg::RISE_SLEW_LSB + regulator_ch3_pkg::CH3_INDEX])
                        ? CW'(regulator_ch3_pkg::SHORT_LATENCY_CYCLES - 1)
                        : CW'(LONG_LATENCY_CYCLES - 1);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ramp_state_q       <= regulator_ch3_pkg::RAMP_IDLE;
      wait_count_q       <= '0;
      ch3_ramp_start_out <= 1'b0;
    end else begin
      ch3_ramp_start_out <= 1'b0;
      if (target_write) begin
        ramp_state_q <= regulator_ch3_pkg::RAMP_WAIT;
        wait_count_q <= latency_load;
      end else begin
        unique case (ramp_state_q)
          regulator_ch3_pkg::RAMP_IDLE: begin
            wait_count_q <= '0;
          end
          regulator_ch3_pkg::RAMP_WAIT: begin
            if (wait_count_q == '0) begin
              ramp_state_q       <= regulator_ch3_pkg::RAMP_IDLE;
              ch3_ramp_start_out <= 1'b1;
            end else begin
              wait_count_q <= wait_count_q - 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // channel 3 output control
  // ****************************************
  ch3_output_control u_ch3_output_control (
    .ref_clk_in                    (ref_clk_in),
    .reset_in                      (reset_in),
    .ch3_target_code_in            (target_q),
    .ch3_fine_step_select_in       (ch3_fine_step_select_in),
    .ch3_discharge_enable_in       (enable_q[regulator_ch3_pkg::DISCHARGE_BIT]),
    .ch3_enable_select_in          (enable_q[regulator_ch3_pkg::ENSEL_MSB:regulator_ch3_pkg::ENSEL_LSB]),
    .power_sequencer_slot_in       (power_sequencer_slot_in),
    .ch3_voltage_out               (ch3_voltage_out),
    .ch3_code_reserved_out         (ch3_code_reserved_out),
    .ch3_enabled_out               (ch3_enabled_out),
    .ch3_discharge_resistor_on_out (ch3_discharge_resistor_on_out)
  );

endmodule
`default_nettype wire

//--- dv/regulator_ch3_config_regs_checker.sv
// assertions on the ports of the channel 3 configuration registers
`timescale 1ns/1ps
`default_nettype none

module regulator_ch3_config_regs_checker (
  // clock, reset and register port
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  // controls and channel state
  input wire logic        ch3_fine_step_select_in,
  input wire logic [3:0]  power_sequencer_slot_in,
  input wire logic [15:0] ch3_voltage_out,
  input wire logic        ch3_code_reserved_out,
  input wire logic        ch3_enabled_out,
  input wire logic        ch3_discharge_resistor_on_out,
  input wire logic        ch3_ramp_start_out,
  input wire logic [15:0] rise_slew_rate_out,
  input wire logic [3:0]  short_latency_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ****************************************
  // register port and channel checks
  // ****************************************
  wire logic  en_wr = reg_write_in && reg_addr_in == 8'h0f;
  wire logic  tv_wr = reg_write_in && reg_addr_in == 8'h0e;
  logic [3:0] slot_q;
  always_ff @(posedge ref_clk_in) begin
    slot_q <= power_sequencer_slot_in;
  end
  property p_code;
    logic [7:0] c;
    (tv_wr, c = reg_wdata_in) ##1 !ch3_fine_step_select_in |=>
      ch3_code_reserved_out == (c > 8'hc8) && ch3_voltage_out == 16'h1388 + 16'(c) * 16'h00fa;
  endproperty
  property p_slot;
    logic [1:0] s;
    (en_wr && !reg_wdata_in[2], s = reg_wdata_in[1:0]) |-> ##2 ch3_enabled_out == slot_q[s];
  endproperty
  property p_fine;
    logic [7:0] c;
    (tv_wr, c = reg_wdata_in) ##1 ch3_fine_step_select_in |=>
      ch3_voltage_out == 16'h1388 + 16'(c) * 16'h007d;
  endproperty
  a_coarse_code_decode: assert property (p_code) else $error("coarse decode wrong");
  a_slot_enable_follow: assert property (p_slot) else $error("slot enable wrong");
  a_forced_on_enables: assert property (en_wr && reg_wdata_in[2:1] == 2'h3 |-> ##2 ch3_enabled_out)
    else $error("forced on not enabled");
  a_forced_off_disables: assert property (en_wr && reg_wdata_in[2:1] == 2'h2 |-> ##2 !ch3_enabled_out)
    else $error("forced off still enabled");
  a_discharge_when_off: assert property (ch3_discharge_resistor_on_out |-> !ch3_enabled_out)
    else $error("discharge while enabled");
  a_discharge_clear_idle: assert property (en_wr && !reg_wdata_in[3] |-> ##2 !ch3_discharge_resistor_on_out)
    else $error("discharge without enable bit");
  a_fine_code_decode: assert property (p_fine) else $error("fine decode wrong");
  a_discharge_forced_off: assert property (en_wr && reg_wdata_in[3] && reg_wdata_in[2:1] == 2'h2 |-> ##2
    ch3_discharge_resistor_on_out) else $error("discharge missing when off");
  a_unmapped_read_zero: assert property (reg_read_in && !(reg_addr_in inside {8'h0e, 8'h0f, 8'h10}) |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_enable_upper_zero: assert property (reg_read_in && reg_addr_in == 8'h0f |=> reg_rdata_out[7:4] == 4'h0)
    else $error("enable upper bits set");
  a_ramp_upper_zero: assert property (reg_read_in && reg_addr_in == 8'h10 |=> reg_rdata_out[7:6] == 2'h0)
    else $error("ramp upper bits set");
  a_ramp_start_late: assert property (tv_wr |=> !ch3_ramp_start_out [*8]) else $error("ramp start early");
  a_ramp_single_pulse: assert property ($rose(ch3_ramp_start_out) |=> !ch3_ramp_start_out)
    else $error("ramp pulse too long");
  c_ramp_start: cover property (ch3_ramp_start_out);
  c_discharge_on: cover property (ch3_discharge_resistor_on_out);
  c_code_reserved: cover property (ch3_code_reserved_out);
endmodule

bind regulator_ch3_config_regs regulator_ch3_config_regs_checker checker_u (.*);
`default_nettype wire

//--- dv/test_regulator_ch3_config_regs.sv
// self-checking bench for the channel 3 configuration registers
`timescale 1ns/1ps
`default_nettype none

module test_regulator_ch3_config_regs;
  // ****************************************
  // signals and design
  // ****************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        fine = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [3:0]  slot = 4'h5;
  logic [7:0]  rdata;
  logic [15:0] volt;
  logic [15:0] rise;
  logic [15:0] e;
  logic [3:0]  short_lat;
  logic        reserved, enabled, discharge, ramp;
  logic [7:0]  codes [5] = '{8'h00, 8'h01, 8'hc8, 8'hc9, 8'hff};
  logic [7:0]  ramps [4] = '{8'h0f, 8'h2a, 8'h15, 8'h3f};
  int          num_errors = 0;
  int          total_checks = 0;
  int          n;

  regulator_ch3_config_regs #(.LONG_LATENCY_CYCLES(20)) dut_u (.ref_clk_in(clk), .reset_in(rst),
    .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .ch3_fine_step_select_in(fine), .power_sequencer_slot_in(slot), .ch3_voltage_out(volt),
    .ch3_code_reserved_out(reserved), .ch3_enabled_out(enabled), .ch3_discharge_resistor_on_out(discharge),
    .ch3_ramp_start_out(ramp), .rise_slew_rate_out(rise), .short_latency_out(short_lat));

  initial begin
    forever #10 clk = ~clk;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(rdata), 16'(exp), "read");
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ramp_wait(input int exp_n);
    wr(8'h0e, 8'h40);
    for (n = 0; n < 600 && ramp !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 600) begin
      num_errors++;
      $display("ERROR %0t ramp start missing", $time);
    end else begin
      chk(16'(n), 16'(exp_n), "ramp delay");
    end
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0f, 8'h00);
    rd(8'h10, 8'h00);
    chk(rise, 16'h2222, "rise reset");
    wr(8'h0f, 8'hf4);
    rd(8'h0f, 8'h04);
    wr(8'h10, 8'hc0);
    rd(8'h10, 8'h00);
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h00);
    $display("test reset and access done");
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      fine <= f[0];
      foreach (codes[i]) begin
        wr(8'h0e, codes[i]);
        settle();
        e = f ? 16'h1388 + 16'(codes[i]) * 16'h007d : 16'h1388 + 16'(codes[i]) * 16'h00fa;
        if (f == 1 || codes[i] <= 8'hc8) chk(volt, e, "voltage");
        chk(16'(reserved), 16'(f == 0 && codes[i] > 8'hc8), "reserved");
      end
    end
    $display("test voltage done");
    for (int s = 0; s < 16; s++) begin
      wr(8'h0f, 8'(s));
      settle();
      e[0] = s[2] ? s[1] : slot[s[1:0]];
      chk(16'(enabled), 16'(e[0]), "enabled");
      chk(16'(discharge), 16'(s[3] & ~e[0]), "discharge");
    end
    wr(8'h0f, 8'h09);
    @(posedge clk);
    slot <= 4'ha;
    settle();
    chk(16'(enabled), 16'h0001, "slot change");
    $display("test enable done");
    foreach (ramps[i]) begin
      wr(8'h10, ramps[i]);
      settle();
      for (int c = 0; c < 4; c++) e[4*c +: 4] = ramps[i][c] ? (ramps[i][5] ? 4'ha : 4'h5) : 4'h2;
      chk(rise, e, "rise slew");
      chk(16'(short_lat), 16'(ramps[i][4] ? ramps[i][3:0] : 4'h0), "short latency");
      rd(8'h10, ramps[i]);
    end
    ramp_wait(500);
    wr(8'h10, 8'h37);
    wr(8'h0e, 8'h20);
    ramp_wait(20);
    $display("test ramp done");
    give_verdict();
  end
endmodule
`default_nettype wire
